// [core/smac_core.sv]
// apb-reached special function register access checker with mode and firewall state
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
//
// Contract
// RQ1: boot mode: all groups except test, system-cpu
// RQ2: test mode: all groups except system-cpu
// RQ3: firmware: read firewall config, rw firmware os
// RQ4: firmware hardware access follows firewall rights bits
// RQ5: system: system mgmt, firewall config, hardware
// RQ6: shared general cpu registers always granted
// RQ7: firmware may read cpu control status
// RQ8: firmware may always read clock source select
// RQ9: system-cpu registers denied outside system mode
// RQ10: mmu pointer register never readable
// RQ11: random number output register never writable
// RQ12: cipher key registers never readable
// RQ13: security attributes reset to restrictive values
// RQ14: app ram config written only in system
// RQ15: memory partition fixed, nothing alters it
// RQ16: exchange area defined only by system mode
// RQ17: eeprom integrity whole access, else firewall area
// RQ18: denied read or write raises exception
// RQ19: four modes tracked, activated in sequence
// RQ20: decision with request; denial blocks write, zeroes data
module smac_core
   import smac_pkg::*;
(
   input wire logic pclk, // 40 mhz core clock
   input wire logic presetn, // async reset, active low
   input wire logic ce, // clock enable, freezes state when low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction, high = write
   input wire logic [ADDR_W-1:0] paddr, // apb byte address
   input wire logic [DATA_W-1:0] pwdata, // apb write data
   output logic [DATA_W-1:0] prdata, // apb read data, zero on denial
   output logic pready, // apb ready
   output logic pslverr, // apb error on denial or unmapped
   input wire logic [DATA_W-1:0] ext_rdata, // read value of addressed external register
   input wire logic ee_integrity_run, // firmware eeprom integrity function active
   output logic ext_wr, // granted write pulse to register groups
   output logic [ADDR_W-1:0] ext_addr, // address of granted write
   output logic [DATA_W-1:0] ext_wdata, // data of granted write
   output logic exc_pulse, // access exception pulse
   output smac_mode_e cpu_mode, // active cpu mode
   output logic [DATA_W-1:0] xchg_base, // ram exchange area base
   output logic [DATA_W-1:0] xchg_size, // ram exchange area size
   output logic [DATA_W-1:0] app_ram_cfg, // application ram configuration
   output logic ee_whole, // eeprom whole-array access window
   output logic ee_fw_area // eeprom limited to firmware area
);

   logic [DATA_W-1:0] fw_ctrl_low;
   logic [DATA_W-1:0] fw_ctrl_high;
   logic [63:0] fw_rights;
   logic [3:0] grp;
   logic [5:0] widx;
   logic rd;
   logic is_boot;
   logic is_test;
   logic is_fw;
   logic is_sys;
   logic mapped;
   logic mode_ok;
   logic fixed_deny;
   logic grant;
   logic internal;
   logic [DATA_W-1:0] int_rdata;
   logic setup_ph;
   logic acc_done;
   logic grant_q;
   logic mapped_q;

   // partition decode is pure wiring of fixed address bits
   assign grp = paddr[11:8]; // RQ15
   assign widx = paddr[7:2];
   assign rd = !pwrite;
   assign fw_rights = {fw_ctrl_high, fw_ctrl_low};
   assign is_boot = (cpu_mode == SMAC_BOOT);
   assign is_test = (cpu_mode == SMAC_TEST);
   assign is_fw = (cpu_mode == SMAC_FW);
   assign is_sys = (cpu_mode == SMAC_SYS);
   assign setup_ph = ce && psel && !penable && !pready;
   assign acc_done = ce && psel && penable && pready;

   // per-group mode permission
   always_comb begin
      mapped = 1'b1;
      mode_ok = 1'b0;
      case (grp)
         GRP_SHARED: mode_ok = 1'b1; // RQ6
         GRP_SYSCPU: mode_ok = is_sys; // RQ9
         GRP_SYSMGT: mode_ok = is_boot || is_test || is_sys ||
                               (is_fw && rd && widx == IDX_CPU_CONTROL_STATUS_REG); // RQ5 RQ7
         GRP_FWCFG: mode_ok = is_boot || is_test || is_sys || (is_fw && rd); // RQ3 RQ5
         GRP_HW: mode_ok = is_boot || is_test || is_sys ||
                           (is_fw && (fw_rights[widx] || (rd && widx == IDX_CLKSEL))); // RQ4 RQ8
         GRP_FWOS: mode_ok = is_boot || is_test || is_fw; // RQ1 RQ2 RQ3
         GRP_TEST: mode_ok = is_test; // RQ1 RQ2
         default: mapped = 1'b0;
      endcase
   end

   // register-specific restrictions that override any mode
   always_comb begin
      fixed_deny = 1'b0;
      if (grp == GRP_SYSMGT && widx == IDX_MMU_PTR && rd) begin
         fixed_deny = 1'b1; // RQ10
      end
      if (grp == GRP_HW && widx == IDX_RNG_OUT && pwrite) begin
         fixed_deny = 1'b1; // RQ11
      end
      if (grp == GRP_HW && widx >= IDX_KEY_FIRST && widx <= IDX_KEY_LAST && rd) begin
         fixed_deny = 1'b1; // RQ12
      end
      if (grp == GRP_HW && widx == IDX_APP_RAM && pwrite && !is_sys) begin
         fixed_deny = 1'b1; // RQ14
      end
      if (grp == GRP_FWCFG && (widx == IDX_XCHG_BASE || widx == IDX_XCHG_SIZE) &&
          pwrite && !is_sys) begin
         fixed_deny = 1'b1; // RQ16
      end
   end

   assign grant = mapped && mode_ok && !fixed_deny;

   // registers held inside the checker, others live in the groups
   always_comb begin
      internal = 1'b1;
      int_rdata = RDATA_ZERO;
      if (grp == GRP_SYSMGT && widx == IDX_CPU_CONTROL_STATUS_REG) begin
         int_rdata = {28'h000_0000, cpu_mode};
      end else if (grp == GRP_FWCFG && widx == IDX_FW_LOW) begin
         int_rdata = fw_ctrl_low;
      end else if (grp == GRP_FWCFG && widx == IDX_FW_HIGH) begin
         int_rdata = fw_ctrl_high;
      end else if (grp == GRP_FWCFG && widx == IDX_XCHG_BASE) begin
         int_rdata = xchg_base;
      end else if (grp == GRP_FWCFG && widx == IDX_XCHG_SIZE) begin
         int_rdata = xchg_size;
      end else if (grp == GRP_HW && widx == IDX_APP_RAM) begin
         int_rdata = app_ram_cfg;
      end else begin
         internal = 1'b0;
      end
   end

   // apb handshake: decision taken in setup, answered in the next cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= RDATA_ZERO;
         grant_q <= 1'b0;
         mapped_q <= 1'b0;
      end else if (ce) begin
         if (setup_ph) begin
            pready <= 1'b1; // RQ20
            pslverr <= !grant; // RQ18
            grant_q <= grant;
            mapped_q <= mapped;
            // denied reads return zero so no secret leaks
            if (grant && rd) begin
               prdata <= internal ? int_rdata : ext_rdata; // RQ20
            end else begin
               prdata <= RDATA_ZERO;
            end
         end else if (acc_done) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RDATA_ZERO;
         end
      end
   end

   // exception on every denied mapped access, one cycle after completion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exc_pulse <= 1'b0;
      end else if (ce) begin
         exc_pulse <= acc_done && mapped_q && !grant_q; // RQ18
      end
   end

   // forward granted writes to external groups
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_wr <= 1'b0;
         ext_addr <= '0;
         ext_wdata <= RDATA_ZERO;
      end else if (ce) begin
         ext_wr <= acc_done && grant_q && pwrite && !internal; // RQ20
         if (acc_done && grant_q && pwrite && !internal) begin
            ext_addr <= paddr;
            ext_wdata <= pwdata;
         end
      end
   end

   // security attributes; reset values grant nothing to firmware
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fw_ctrl_low <= RST_FW_CTRL; // RQ13
         fw_ctrl_high <= RST_FW_CTRL; // RQ13
         xchg_base <= RST_XCHG; // RQ13
         xchg_size <= RST_XCHG; // RQ13
         app_ram_cfg <= RST_APP_RAM; // RQ13
      end else if (ce && acc_done && grant_q && pwrite) begin
         if (grp == GRP_FWCFG && widx == IDX_FW_LOW) begin
            fw_ctrl_low <= pwdata;
         end
         if (grp == GRP_FWCFG && widx == IDX_FW_HIGH) begin
            fw_ctrl_high <= pwdata;
         end
         if (grp == GRP_FWCFG && widx == IDX_XCHG_BASE) begin
            xchg_base <= pwdata; // RQ16
         end
         if (grp == GRP_FWCFG && widx == IDX_XCHG_SIZE) begin
            xchg_size <= pwdata; // RQ16
         end
         if (grp == GRP_HW && widx == IDX_APP_RAM) begin
            app_ram_cfg <= pwdata; // RQ14
         end
      end
   end

   // mode only moves forward; an illegal or backward code is ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_mode <= SMAC_BOOT; // RQ13 RQ19
      end else if (ce && acc_done && grant_q && pwrite &&
                   grp == GRP_SYSMGT && widx == IDX_CPU_CONTROL_STATUS_REG) begin
         case (pwdata[3:0])
            SMAC_BOOT, SMAC_TEST, SMAC_FW, SMAC_SYS: begin
               if (pwdata[3:0] >= cpu_mode) begin
                  cpu_mode <= smac_mode_e'(pwdata[3:0]); // RQ19
               end
            end
            default: cpu_mode <= cpu_mode;
         endcase
      end
   end

   // eeprom window: integrity function sees all, the rest only its area
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ee_whole <= 1'b0;
         ee_fw_area <= 1'b0;
      end else if (ce) begin
         ee_whole <= is_fw && ee_integrity_run; // RQ17
         ee_fw_area <= is_fw && !ee_integrity_run; // RQ17
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence setup_s;
      psel && !penable && !pready && ce;
   endsequence

   sequence done_s;
      psel && penable && pready && ce;
   endsequence

   answer_next_a: assert property (setup_s |=> pready) // RQ20
      else $error("no ready one cycle after setup");
   ptr_noread_a: assert property ((setup_s and (rd && grp == GRP_SYSMGT &&
                                  widx == IDX_MMU_PTR)) |=> pslverr && prdata == RDATA_ZERO) // RQ10
      else $error("mmu pointer read not denied");
   rng_wr_exc_a: assert property ((setup_s and (pwrite && grp == GRP_HW &&
                                  widx == IDX_RNG_OUT)) ##1 done_s |=> exc_pulse) // RQ11
      else $error("random output write gave no exception");
   key_noread_a: assert property ((setup_s and (rd && grp == GRP_HW &&
                                  widx == IDX_KEY_FIRST)) |=> pslverr && prdata == RDATA_ZERO) // RQ12
      else $error("key register read not denied");
   shared_grant_a: assert property ((setup_s and (grp == GRP_SHARED)) |=> !pslverr) // RQ6
      else $error("shared register access denied");
   syscpu_deny_a: assert property ((setup_s and (grp == GRP_SYSCPU && !is_sys)) |=> pslverr) // RQ9
      else $error("system cpu register reachable outside system mode");
   test_boot_a: assert property ((setup_s and (grp == GRP_TEST && is_boot)) |=> pslverr) // RQ1
      else $error("test register reachable in boot mode");
   appram_hold_a: assert property ((setup_s and (pwrite && grp == GRP_HW &&
                                   widx == IDX_APP_RAM && !is_sys)) ##1 done_s
                                   |=> $stable(app_ram_cfg)) // RQ14
      else $error("app ram config written outside system mode");
   // rising edge only: a pulse frozen by a low enable must not look like a fresh one
   exc_cause_a: assert property ($rose(exc_pulse) |-> $past(pslverr && pready)) // RQ18
      else $error("exception without denied access");
   fw_ctrl_src_a: assert property ($changed(fw_ctrl_low) |-> $past(grant_q && pwrite && pready)) // RQ4
      else $error("firewall rights changed without granted write");
   mode_fwd_a: assert property (!$stable(cpu_mode) |-> cpu_mode > $past(cpu_mode)) // RQ19
      else $error("cpu mode moved backward");

endmodule : smac_core

// [pkg/smac_pkg.sv]
// shared constants and types for the special function register access checker
package smac_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // cpu modes, one-hot, numeric order is the activation sequence
   typedef enum logic [3:0] {
      SMAC_BOOT = 4'b0001,
      SMAC_TEST = 4'b0010,
      SMAC_FW   = 4'b0100,
      SMAC_SYS  = 4'b1000
   } smac_mode_e;
   // register group = paddr[11:8], fixed partition
   localparam logic [3:0] GRP_SHARED = 4'h0; // general cpu, all modes
   localparam logic [3:0] GRP_SYSCPU = 4'h1; // general cpu, system mode copy
   localparam logic [3:0] GRP_SYSMGT = 4'h2; // system management
   localparam logic [3:0] GRP_FWCFG = 4'h3; // firmware firewall configuration
   localparam logic [3:0] GRP_HW = 4'h4; // hardware components
   localparam logic [3:0] GRP_FWOS = 4'h5; // firmware os and resource config
   localparam logic [3:0] GRP_TEST = 4'h6; // test registers
   // word indexes inside a group (paddr[7:2])
   localparam logic [5:0] IDX_CPU_CONTROL_STATUS_REG = 6'h00; // sysmgt, internal
   localparam logic [5:0] IDX_MMU_PTR = 6'h01; // sysmgt, external
   localparam logic [5:0] IDX_FW_LOW = 6'h00; // fwcfg, internal
   localparam logic [5:0] IDX_FW_HIGH = 6'h01; // fwcfg, internal
   localparam logic [5:0] IDX_XCHG_BASE = 6'h02; // fwcfg, internal
   localparam logic [5:0] IDX_XCHG_SIZE = 6'h03; // fwcfg, internal
   localparam logic [5:0] IDX_APP_RAM = 6'h00; // hw, internal
   localparam logic [5:0] IDX_CLKSEL = 6'h01; // hw, external
   localparam logic [5:0] IDX_RNG_OUT = 6'h02; // hw, external
   localparam logic [5:0] IDX_KEY_FIRST = 6'h04; // hw, external
   localparam logic [5:0] IDX_KEY_LAST = 6'h07; // hw, external
   // restrictive reset values
   localparam logic [31:0] RST_FW_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_XCHG = 32'h0000_0000;
   localparam logic [31:0] RST_APP_RAM = 32'h0000_0000;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage : smac_pkg

// [testbench/smac_regs_model.sv]
// register group stand-in: answers external reads and stores granted writes
`timescale 1ns/1ps
module smac_regs_model
   import smac_pkg::*;
(
   input wire logic pclk, // core clock
   input wire logic presetn, // async reset, active low
   input wire logic [ADDR_W-1:0] paddr, // address being decoded
   input wire logic ext_wr, // granted write pulse
   input wire logic [ADDR_W-1:0] ext_addr, // granted write address
   input wire logic [DATA_W-1:0] ext_wdata, // granted write data
   output logic [DATA_W-1:0] ext_rdata // addressed word
);
   logic [DATA_W-1:0] mem [0:63];
   // groups alias on the word index so every value stays predictable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 64; i++) begin
            mem[i] <= 32'ha5a5_0000 | 32'(i);
         end
      end else if (ext_wr) begin
         mem[ext_addr[7:2]] <= ext_wdata;
      end
   end
   // combinational so the word is valid in the setup cycle
   assign ext_rdata = mem[paddr[7:2]];
endmodule : smac_regs_model

// [testbench/sfr_mode_access_checker_bench.sv]
// self-checking bench: apb accesses in every cpu mode against the access policy
`timescale 1ns/1ps
module sfr_mode_access_checker_bench
   import smac_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic ee_integrity_run = 1'b0;
   logic ce = 1'b1;
   logic [DATA_W-1:0] prdata, ext_rdata, ext_wdata, xchg_base, xchg_size, app_ram_cfg;
   logic [ADDR_W-1:0] ext_addr;
   logic pready, pslverr, ext_wr, exc_pulse, ee_whole, ee_fw_area;
   smac_mode_e cpu_mode;
   int n_errors = 0;
   int check_count = 0;

   always #12.5 pclk = ~pclk;

   smac_core dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_rdata(ext_rdata), .ee_integrity_run(ee_integrity_run),
      .ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .exc_pulse(exc_pulse),
      .cpu_mode(cpu_mode), .xchg_base(xchg_base), .xchg_size(xchg_size), .app_ram_cfg(app_ram_cfg),
      .ee_whole(ee_whole), .ee_fw_area(ee_fw_area));

   smac_regs_model regs (.pclk(pclk), .presetn(presetn), .paddr(paddr), .ext_wr(ext_wr),
      .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; e = expected denial, r = expected read data
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic e, input logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      chk(32'(pslverr), 32'(e));
      if (!w) chk(prdata, e ? RDATA_ZERO : r);
      psel <= 1'b0;
      penable <= 1'b0;
      // exception follows the completion edge, only for mapped groups
      @(posedge pclk);
      chk(32'(exc_pulse), 32'(e && a[11:8] < 4'h7));
   endtask : acc

   task automatic rst();
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(32'(cpu_mode), 32'(SMAC_BOOT));
      chk(app_ram_cfg, RST_APP_RAM);
      chk(xchg_base, RST_XCHG);
      chk(xchg_size, RST_XCHG);
   endtask : rst

   task automatic summarize();
      if (n_errors == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   // watchdog sized well beyond the under two hundred cycles the sequence needs
   initial begin
      #(25 * 3000);
      n_errors++;
      summarize();
   end

   initial begin
      rst();
      acc(0, 12'h300, 0, 0, RST_FW_CTRL);
      acc(0, 12'h308, 0, 0, RST_XCHG);
      acc(0, 12'h600, 0, 1, 0);
      acc(0, 12'h100, 0, 1, 0);
      acc(0, 12'h700, 0, 1, 0);
      acc(0, 12'h204, 0, 1, 0);
      acc(0, 12'h410, 0, 1, 0);
      acc(1, 12'h408, 32'h11, 1, 0);
      acc(1, 12'h308, 32'h22, 1, 0);
      acc(1, 12'h400, 32'h33, 1, 0);
      acc(1, 12'h200, 32'h2, 0, 0);
      chk(32'(cpu_mode), 32'(SMAC_TEST));
      acc(0, 12'h600, 0, 0, 32'ha5a5_0000);
      acc(0, 12'h100, 0, 1, 0);
      acc(1, 12'h200, 32'h8, 0, 0);
      acc(1, 12'h400, 32'h1234, 0, 0);
      acc(0, 12'h400, 0, 0, 32'h1234);
      acc(1, 12'h308, 32'h55, 0, 0);
      chk(xchg_base, 32'h55);
      acc(1, 12'h30c, 32'h66, 0, 0);
      chk(xchg_size, 32'h66);
      acc(0, 12'h100, 0, 0, 32'ha5a5_0000);
      acc(1, 12'h404, 32'h77, 0, 0);
      acc(0, 12'h404, 0, 0, 32'h77);
      acc(0, 12'h204, 0, 1, 0);
      acc(0, 12'h500, 0, 1, 0);
      rst();
      acc(1, 12'h300, 32'h8, 0, 0);
      acc(1, 12'h200, 32'h4, 0, 0);
      acc(0, 12'h000, 0, 0, 32'ha5a5_0000);
      acc(0, 12'h300, 0, 0, 32'h8);
      acc(1, 12'h300, 32'hff, 1, 0);
      acc(1, 12'h500, 32'h66, 0, 0);
      acc(0, 12'h500, 0, 0, 32'h66);
      acc(0, 12'h200, 0, 0, 32'h4);
      acc(0, 12'h404, 0, 0, 32'ha5a5_0001);
      acc(1, 12'h404, 32'h9, 1, 0);
      acc(1, 12'h40c, 32'h44, 0, 0);
      chk(32'(ext_addr), 32'h0000_040c);
      chk(ext_wdata, 32'h0000_0044);
      acc(0, 12'h40c, 0, 0, 32'h44);
      acc(0, 12'h420, 0, 1, 0);
      acc(0, 12'h100, 0, 1, 0);
      acc(1, 12'h400, 32'h5, 1, 0);
      acc(1, 12'h30c, 32'h5, 1, 0);
      // integrity window follows the run flag one cycle later
      ee_integrity_run <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(32'({ee_whole, ee_fw_area}), 32'h2);
      ee_integrity_run <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'({ee_whole, ee_fw_area}), 32'h1);
      // low clock enable must hold the window despite the flag change
      ce <= 1'b0;
      ee_integrity_run <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(32'({ee_whole, ee_fw_area}), 32'h1);
      ce <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(32'({ee_whole, ee_fw_area}), 32'h2);
      summarize();
   end
endmodule : sfr_mode_access_checker_bench
